// File: src/paged_memory_pkg.sv
// shared constants for the paged memory addressing block
package paged_memory_pkg;

	// =====================================================
	// rom space
	localparam int        ROM_ADDR_W   = 18;      // enough for 208k words
	localparam int        ROM_DATA_W   = 10;      // word width of the rom
	localparam int        BRANCH_W     = 14;      // long branch target width
	localparam int        PAGE_WORDS   = 16384;   // one program page
	localparam int        ROM_WORDS    = 212992;  // 208k words
	localparam int        RSV_WORDS    = 16;      // system info at the top
	localparam int        PROG_PAGE_W  = ROM_ADDR_W - BRANCH_W;
	localparam logic [3:0] PROG_PAGE_RST = 4'h0;  // program page after reset

	// =====================================================
	// data space
	localparam int        NIB_W        = 4;       // one nibble
	localparam int        DADDR_W      = 6;       // data address 0x00..0x3f
	localparam int        RAM_PAGES    = 4;
	localparam int        PAGE_NIBBLES = 56;
	localparam int        RAM_NIBBLES  = 224;
	localparam int        RAM_IDX_W    = 8;       // index into 224 nibbles
	localparam logic [1:0] RAM_PAGE_RST = 2'h0;  // ram page after reset
	localparam logic [5:0] RAM_BASE     = 6'h08;  // first ram address
	localparam logic [5:0] MEMREG_LAST  = 6'h07;  // last memory register

	// =====================================================
	// control register space
	localparam int        SYS_REGS     = 9;
	localparam int        MEM_REGS     = 8;
	localparam int        CTRL_NIBBLES = SYS_REGS + MEM_REGS;

	// =====================================================
	// memory register offsets
	localparam logic [2:0] WINDOW_OFS   = 3'h0;  // indexed data window
	localparam logic [2:0] IDX_LO_OFS   = 3'h1;  // index address, low nibble
	localparam logic [2:0] IDX_HI_OFS   = 3'h2;  // index address, high bits
	localparam logic [2:0] IDX_PAGE_OFS = 3'h3;  // index page pointer

endpackage

// File: src/paged_ram.sv
// 224-nibble data ram, combinational read, clocked write
`timescale 1ns/1ns
`default_nettype none
module paged_ram
	import paged_memory_pkg::*;
#(
	parameter int DEPTH = RAM_NIBBLES
)
(
	// clock
	input  wire logic                 clk,
	// write port
	input  wire logic                 wrEn,
	input  wire logic [RAM_IDX_W-1:0] wrIdx,
	input  wire logic [NIB_W-1:0]     wrData,
	// read port
	input  wire logic [RAM_IDX_W-1:0] rdIdx,
	output var  logic [NIB_W-1:0]     rdData
);

	// =====================================================
	// storage
	logic [NIB_W-1:0] mem [DEPTH];  // no reset: ram content is undefined

	// write side
	always_ff @(posedge clk)
	begin
		if (wrEn)
			mem[wrIdx] <= wrData;
	end

	// read side, caller registers the result
	always_comb
	begin
		rdData = mem[rdIdx];
	end

endmodule // paged_ram
`default_nettype wire

// File: src/paged_memory_addressing.sv
// rom page and paged data ram address mapping for a 4-bit core
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module paged_memory_addressing
	import paged_memory_pkg::*;
#(
	parameter int ROM_SIZE = ROM_WORDS,  // words fitted on this body
	parameter int RSV_SIZE = RSV_WORDS   // system words at the top
)
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// program fetch and branching
	input  wire logic                   fetchReq,
	input  wire logic [BRANCH_W-1:0]    pc,
	input  wire logic                   longBranch,
	input  wire logic [BRANCH_W-1:0]    branchTarget,
	input  wire logic                   progPageLoad,
	input  wire logic [PROG_PAGE_W-1:0] progPageValue,
	// voice data rom reads
	input  wire logic                   voiceReq,
	input  wire logic [ROM_ADDR_W-1:0]  voiceAddr,
	// rom side answer
	output logic      [ROM_ADDR_W-1:0]  romAddr,
	output logic                        romValid,
	output logic                        romReject,
	// data space access from the core
	input  wire logic [DADDR_W-1:0]     dAddr,
	input  wire logic                   dWr,
	input  wire logic                   dRd,
	input  wire logic [NIB_W-1:0]       dWdata,
	output logic      [NIB_W-1:0]       dRdata,
	// page load instruction
	input  wire logic                   pageLoad,
	input  wire logic [1:0]             pageValue,
	// state visible to the core
	output logic      [1:0]             ramPageSelect,
	output logic      [PROG_PAGE_W-1:0] progPage
);

	// =====================================================
	// helpers

	// physical ram index from page and data address
	function automatic logic [RAM_IDX_W-1:0] ramIndex(
		input logic [1:0]         page,
		input logic [DADDR_W-1:0] addr
	);
		logic [RAM_IDX_W-1:0] base;
		base = RAM_IDX_W'(page) * RAM_IDX_W'(PAGE_NIBBLES);
		ramIndex = base + RAM_IDX_W'(addr - RAM_BASE);
	endfunction

	// address lands in the ram part of the data space
	function automatic logic isRam(input logic [DADDR_W-1:0] addr);
		isRam = (addr >= RAM_BASE);
	endfunction

	// word may be handed to user code
	function automatic logic romUsable(input logic [ROM_ADDR_W-1:0] a);
		romUsable = (int'(a) < ROM_SIZE - RSV_SIZE);
	endfunction

	// =====================================================
	// rom address forming

	logic [ROM_ADDR_W-1:0] next_romAddr;  // address chosen this cycle
	logic                  next_romReq;   // any rom request this cycle

	// branch wins over sequential fetch, fetch over voice reads
	always_comb
	begin
		next_romReq = longBranch | fetchReq | voiceReq;
		if (longBranch)
			next_romAddr = {progPage, branchTarget};
		else if (fetchReq)
			next_romAddr = {progPage, pc};
		else
			next_romAddr = voiceAddr;
	end

	// program page only moves on an explicit page load
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			progPage <= PROG_PAGE_RST;
		else if (progPageLoad)
			progPage <= progPageValue;
	end

	// registered rom answer; reserved words are never passed on
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			romAddr   <= '0;
			romValid  <= 1'b0;
			romReject <= 1'b0;
		end
		else
		begin
			romValid  <= next_romReq && romUsable(next_romAddr);
			romReject <= next_romReq && !romUsable(next_romAddr);
			// a refused address is not shown, so nothing can read it
			if (next_romReq && romUsable(next_romAddr))
				romAddr <= next_romAddr;
		end
	end

	// =====================================================
	// ram page select

	// no data address writes this; only the page load does
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ramPageSelect <= RAM_PAGE_RST;
		else if (pageLoad)
			ramPageSelect <= pageValue;
	end

	// =====================================================
	// memory registers

	logic [NIB_W-1:0] memReg [MEM_REGS];  // eight memory nibbles
	logic [DADDR_W-1:0] idxAddr;          // index address pointer
	logic [1:0]         idxPage;          // index page pointer
	logic               regHit;           // access in 0x00..0x07
	logic               winHit;           // access to the data window
	logic [2:0]         regOfs;           // memory register number

	assign regOfs  = dAddr[2:0];
	assign regHit  = !isRam(dAddr);
	assign winHit  = regHit && (regOfs == WINDOW_OFS);
	assign idxAddr = {memReg[IDX_HI_OFS][1:0], memReg[IDX_LO_OFS]};
	assign idxPage = memReg[IDX_PAGE_OFS][1:0];

	// plain nibble storage for every slot except the window
	genvar g;
	generate
		for (g = 0; g < MEM_REGS; g++)
		begin : g_memreg
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					memReg[g] <= '0;
				else if (dWr && regHit && regOfs == 3'(g)
					&& 3'(g) != WINDOW_OFS)
					memReg[g] <= dWdata;
			end
		end
	endgenerate

	// =====================================================
	// ram access path

	logic [RAM_IDX_W-1:0] ramIdx;    // physical nibble addressed
	logic                 ramSel;    // access targets the ram
	logic [NIB_W-1:0]     ramData;   // ram read data
	logic                 idxValid;  // index pointer names a ram nibble

	// window follows the pointers, immediate follows the page
	always_comb
	begin
		idxValid = isRam(idxAddr);
		if (winHit)
		begin
			ramSel = idxValid;
			ramIdx = ramIndex(idxPage, idxAddr);
		end
		else
		begin
			ramSel = isRam(dAddr);
			ramIdx = ramIndex(ramPageSelect, dAddr);
		end
	end

	// 224 nibbles in four pages of 56
	paged_ram #(
		.DEPTH (RAM_NIBBLES)
	) u_ram (
		.clk    (clk),
		.wrEn   (dWr && ramSel),
		.wrIdx  (ramIdx),
		.wrData (dWdata),
		.rdIdx  (ramIdx),
		.rdData (ramData)
	);

	// read data stands one cycle after the read strobe
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			dRdata <= '0;
		else if (dRd)
		begin
			if (ramSel)
				dRdata <= ramData;
			else if (regHit && !winHit)
				dRdata <= memReg[regOfs];
			else
				dRdata <= '0;  // window pointing below ram
		end
	end

	// =====================================================
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence branchSeq;
		longBranch ##0 romUsable({progPage, branchTarget});
	endsequence

	branch_keeps_page_a: assert property (
		branchSeq |=> romAddr == {$past(progPage), $past(branchTarget)})
		else $error("long branch left its program page");

	reserved_never_out_a: assert property (
		romValid |-> int'(romAddr) < ROM_SIZE - RSV_SIZE)
		else $error("reserved rom word handed out");

	reserved_rejected_a: assert property (
		(next_romReq && !romUsable(next_romAddr)) |=> romReject && !romValid)
		else $error("reserved rom request not refused");

	page_load_only_a: assert property (
		!pageLoad |=> $stable(ramPageSelect))
		else $error("ram page moved without page load");

	page_load_takes_a: assert property (
		pageLoad |=> ramPageSelect == $past(pageValue))
		else $error("page load value not taken");

	ram_range_a: assert property (
		ramSel |-> ramIdx < RAM_IDX_W'(RAM_NIBBLES))
		else $error("ram index past 224 nibbles");

	// expected index worked out apart from the helper function
	imm_page_map_a: assert property (
		(ramSel && !winHit) |-> int'(ramIdx) == int'(ramPageSelect)
			* PAGE_NIBBLES + int'(dAddr) - int'(RAM_BASE))
		else $error("immediate ram index ignores page");

	sequence regWrSeq;
		dWr && regHit && !winHit ##1 dRd && $past(dAddr) == dAddr;
	endsequence

	reg_readback_a: assert property (
		regWrSeq |=> dRdata == $past(dWdata, 2))
		else $error("memory register readback wrong");

	window_map_a: assert property (
		(winHit && idxValid) |-> ramSel
			&& int'(ramIdx) == int'(idxPage) * PAGE_NIBBLES
			+ int'(idxAddr) - int'(RAM_BASE))
		else $error("window does not follow pointers");

endmodule // paged_memory_addressing
`default_nettype wire

// File: tb/core_model.sv
// core side model issuing data space strobes
`timescale 1ns/1ns
`default_nettype none
module core_model
	import paged_memory_pkg::*;
(
	// clock
	input  wire logic               clk,
	// data space strobes
	output var  logic [DADDR_W-1:0] dAddr,
	output var  logic               dWr,
	output var  logic               dRd,
	output var  logic [NIB_W-1:0]   dWdata,
	// read answer
	input  wire logic [NIB_W-1:0]   dRdata
);
	// ==========================================
	// idle bus from time zero
	initial
	begin
		dAddr  = 6'h00;
		dWr    = 1'b0;
		dRd    = 1'b0;
		dWdata = 4'h0;
	end
	// one-cycle write; data scrambled after release
	task automatic wr(input logic [5:0] a, input logic [3:0] d);
		@(posedge clk);
		dAddr  <= a;
		dWdata <= d;
		dWr    <= 1'b1;
		@(posedge clk);
		dWr    <= 1'b0;
		dWdata <= ~d;  // stale value must not look valid
	endtask
	// one-cycle read; answer sampled in the next cycle
	task automatic rd(input logic [5:0] a, output logic [3:0] d);
		@(posedge clk);
		dAddr <= a;
		dRd   <= 1'b1;
		@(posedge clk);
		dRd   <= 1'b0;
		dAddr <= ~a;
		#1;
		d = dRdata;
	endtask
	// write then read of one address with no idle cycle between
	task automatic wr_rd(input logic [5:0] a, input logic [3:0] d,
		output logic [3:0] q);
		@(posedge clk);
		dAddr  <= a;
		dWdata <= d;
		dWr    <= 1'b1;
		@(posedge clk);
		dWr    <= 1'b0;
		dRd    <= 1'b1;
		@(posedge clk);
		dRd    <= 1'b0;
		dAddr  <= ~a;
		dWdata <= ~d;
		#1;
		q = dRdata;
	endtask
endmodule // core_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the paged memory addressing block
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import paged_memory_pkg::*;
;
	// ==========================================
	// rom request rows: inputs beside expected answer
	typedef struct packed {
		logic lb; logic fr; logic vr;
		logic [13:0] off; logic [17:0] va;
		logic ok; logic [17:0] ea;
	} rom_row_t;
	localparam logic [17:0] LIM = 18'(ROM_WORDS - RSV_WORDS);
	rom_row_t rows [5];
	logic clk = 1'b0, arst_n = 1'b0;
	logic fetchReq = 1'b0, longBranch = 1'b0, voiceReq = 1'b0;
	logic progPageLoad = 1'b0, pageLoad = 1'b0;
	logic [13:0] pc = 14'h0000, branchTarget = 14'h0000;
	logic [3:0]  progPageValue = 4'h0, progPage, q;
	logic [17:0] voiceAddr = 18'h00000, romAddr;
	logic        romValid, romReject;
	logic [5:0]  dAddr;
	logic        dWr, dRd;
	logic [3:0]  dWdata, dRdata;
	logic [1:0]  pageValue = 2'h0, ramPageSelect;
	int          fails = 0, n_checks = 0;
	// ==========================================
	// clock, 40 ns period
	always #20 clk = ~clk;
	paged_memory_addressing i_paged_memory_addressing (.clk(clk),
		.arst_n(arst_n), .fetchReq(fetchReq), .pc(pc),
		.longBranch(longBranch), .branchTarget(branchTarget),
		.progPageLoad(progPageLoad), .progPageValue(progPageValue),
		.voiceReq(voiceReq), .voiceAddr(voiceAddr), .romAddr(romAddr),
		.romValid(romValid), .romReject(romReject), .dAddr(dAddr),
		.dWr(dWr), .dRd(dRd), .dWdata(dWdata), .dRdata(dRdata),
		.pageLoad(pageLoad), .pageValue(pageValue),
		.ramPageSelect(ramPageSelect), .progPage(progPage));
	core_model i_core_model (.clk(clk), .dAddr(dAddr), .dWr(dWr),
		.dRd(dRd), .dWdata(dWdata), .dRdata(dRdata));
	// ==========================================
	// compare and verdict
	task automatic chk(input string n, input logic [17:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ram page load pulse
	task automatic load_page(input logic [1:0] v);
		@(posedge clk);
		pageLoad  <= 1'b1;
		pageValue <= v;
		@(posedge clk);
		pageLoad  <= 1'b0;
		#1;
		chk("page", 18'(v), 18'(ramPageSelect));
	endtask
	// read and compare one data address
	task automatic rc(input logic [5:0] a, input logic [3:0] e);
		i_core_model.rd(a, q);
		chk("rdata", 18'(e), 18'(q));
	endtask
	// ==========================================
	// watchdog, far beyond the roughly eighty cycles used
	initial
	begin
		#200000;
		fails++;
		tally_and_finish();
	end
	// ==========================================
	// main sequence
	initial
	begin
		rows[0] = '{1, 1, 0, 14'h1234, 0, 1, 18'h0d234};
		rows[1] = '{0, 1, 1, 14'h0000, 0, 1, 18'h0ffff};
		rows[2] = '{0, 0, 1, 0, LIM - 18'h1, 1, LIM - 18'h1};
		rows[3] = '{0, 0, 1, 0, LIM, 0, LIM - 18'h1};
		rows[4] = '{0, 1, 1, 14'h3ffe, LIM, 1, 18'h0c001};
		repeat (4) @(posedge clk);
		chk("rst", 18'h0, romAddr);
		chk("rstv", 18'h0, 18'({romValid, romReject}));
		chk("rstpg", 18'h0, 18'({ramPageSelect, progPage, dRdata}));
		arst_n <= 1'b1;
		@(posedge clk);
		progPageLoad  <= 1'b1;
		progPageValue <= 4'h3;
		@(posedge clk);
		progPageLoad  <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge clk);
			{longBranch, fetchReq, voiceReq} <= {rows[i].lb, rows[i].fr,
				rows[i].vr};
			branchTarget <= rows[i].off;
			pc           <= ~rows[i].off;
			voiceAddr    <= rows[i].va;
			@(posedge clk);
			{longBranch, fetchReq, voiceReq} <= 3'b000;
			#1;
			chk("valid", 18'(rows[i].ok), 18'(romValid));
			chk("reject", 18'(!rows[i].ok), 18'(romReject));
			chk("romaddr", rows[i].ea, romAddr);
		end
		// immediate accesses follow the page select
		i_core_model.wr(6'h08, 4'ha);
		load_page(2'h2);
		i_core_model.wr(6'h08, 4'hb);
		i_core_model.wr(6'h3f, 4'hc);
		rc(6'h08, 4'hb);
		load_page(2'h3);
		i_core_model.wr(6'h3f, 4'he);
		load_page(2'h0);
		rc(6'h08, 4'ha);
		i_core_model.wr(6'h04, 4'h6);
		rc(6'h04, 4'h6);
		rc(6'h08, 4'ha);
		// indexed access: pointers first, then the window
		i_core_model.wr(6'h01, 4'h9);
		i_core_model.wr(6'h02, 4'h1);
		i_core_model.wr(6'h03, 4'h2);
		i_core_model.wr(6'h00, 4'h5);
		load_page(2'h2);
		rc(6'h19, 4'h5);
		rc(6'h3f, 4'hc);
		rc(6'h00, 4'h5);
		// back-to-back write and read of one memory register
		i_core_model.wr_rd(6'h05, 4'h3, q);
		chk("wrrd", 18'h3, 18'(q));
		// window below ram start is refused
		i_core_model.wr(6'h01, 4'h3);
		i_core_model.wr(6'h02, 4'h0);
		i_core_model.wr(6'h00, 4'h7);
		rc(6'h00, 4'h0);
		rc(6'h01, 4'h3);
		chk("pagekeep", 18'h2, 18'(ramPageSelect));
		// last page holds its own top nibble
		load_page(2'h3);
		rc(6'h3f, 4'he);
		// reset in mid-run clears the page select
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		#1;
		chk("rst2", 18'h0, 18'({ramPageSelect, progPage}));
		@(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("rst3", 18'h0, 18'({romValid, romReject, ramPageSelect}));
		chk("rst3a", 18'h0, romAddr);
		rc(6'h05, 4'h0);
		load_page(2'h1);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
